// >>> pkg/svs_pkg.sv
// shared constants and carriers for the stereo signalling sink end
// assumes a single 10 MHz clock and byte-wide link-side streams
package svs_pkg;

    // clock period in ns, kept for derived timing
    localparam int unsigned CLK_PERIOD_NS = 100;

    // burst identifiers for the two stereo lists (both bytes carried)
    localparam logic [15:0] SHORT_LIST_ID = 16'h0010;
    localparam logic [15:0] DETAILED_LIST_ID = 16'h0011;

    // burst layout byte offsets
    localparam logic [3:0] OFS_ID_HI = 4'h0;
    localparam logic [3:0] OFS_ID_LO = 4'h1;
    localparam logic [3:0] OFS_CHECKSUM = 4'h2;
    localparam logic [3:0] OFS_TOTAL = 4'h3;
    localparam logic [3:0] OFS_SEQ = 4'h4;
    localparam logic [3:0] OFS_NUM = 4'h5;
    localparam logic [3:0] OFS_DESC = 4'h6;
    localparam logic [3:0] MAX_PER_BURST = 4'h5;
    localparam logic [7:0] FIRST_SEQ = 8'h01;
    localparam int unsigned MAX_ENTRIES = 8;

    // descriptor low byte bit positions
    localparam int unsigned BIT_FRAME_SEQ = 0;
    localparam int unsigned BIT_OVER_UNDER = 1;
    localparam int unsigned BIT_SIDE_BY_SIDE = 2;

    // vendor info packet header and payload positions
    localparam logic [7:0] INFO_TYPE = 8'h81;
    localparam logic [7:0] INFO_VERSION = 8'h01;
    localparam logic [4:0] IDX_HB0 = 5'h00;
    localparam logic [4:0] IDX_HB1 = 5'h01;
    localparam logic [4:0] IDX_HB2 = 5'h02;
    localparam logic [4:0] IDX_PB1 = 5'h04;
    localparam logic [4:0] IDX_PB2 = 5'h05;
    localparam logic [4:0] IDX_PB3 = 5'h06;
    localparam logic [4:0] IDX_PB4 = 5'h07;
    localparam logic [4:0] MIN_INFO_LEN = 5'h04;
    // organization identifier: value arbitrary
    localparam logic [23:0] ORG_ID = 24'h123456;

    // format indicator and layout codes
    localparam logic [1:0] FMT_NONE = 2'h0;
    localparam logic [1:0] FMT_STEREO = 2'h1;
    localparam logic [3:0] LAYOUT_FRAME_SEQ = 4'h0;
    localparam logic [3:0] LAYOUT_OVER_UNDER = 4'h1;
    localparam logic [3:0] LAYOUT_SIDE_BY_SIDE = 4'h2;

    // fields without a good packet before the layout is dropped
    localparam logic [1:0] STALE_FIELDS = 2'h2;

    // active stereo indication as decoded from a good packet
    typedef struct packed {
        logic [1:0] fmt;
        logic [3:0] layout;
    } svs_mode_t;

    // current raster position, 1-based, and active extents
    typedef struct packed {
        logic [11:0] line_num;
        logic [11:0] active_lines;
        logic [11:0] pixel_num;
        logic [11:0] active_pixels;
    } svs_raster_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_SEND
    } svs_state_t;

endpackage

// >>> sim/svs_sink_asserts.sv
// assertions on the ports of the stereo signalling sink end
// bound from the bench top; one clock, reset active low
`timescale 1ns/1ps
module svs_sink_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // burst side
    input wire logic stereo_support_request,
    input wire logic burst_valid,
    input wire logic [7:0] burst_byte,
    input wire logic burst_last,
    input wire logic burst_ready,
    input wire logic burst_busy,
    // format, packet and eye side
    input wire logic [7:0] video_format_code,
    input wire logic avi_present,
    input wire logic [7:0] measured_format,
    input wire logic [7:0] applied_format,
    input wire svs_pkg::svs_raster_t raster,
    input wire svs_pkg::svs_mode_t active_mode,
    input wire logic mode_valid,
    input wire logic pkt_good,
    input wire logic pkt_bad,
    input wire logic right_eye
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic ou, sbs;
    assign ou = mode_valid && active_mode.layout == 4'h1;
    assign sbs = mode_valid && active_mode.layout == 4'h2;
    a_burst_hold: assert property (burst_valid && !burst_ready |=>
        burst_valid && $stable(burst_byte) && $stable(burst_last))
        else $error("burst byte changed before accept");
    a_req_answer: assert property (stereo_support_request && !burst_busy
        |-> ##[1:3] burst_valid) else $error("request not answered");
    a_burst_identifier: assert property ($rose(burst_valid) |->
        burst_byte == 8'h00) else $error("burst does not open with id");
    a_burst_gap: assert property (burst_valid && burst_ready && burst_last
        |=> !burst_valid) else $error("no gap after last byte");
    a_pkt_excl: assert property (!(pkt_good && pkt_bad))
        else $error("good and bad together");
    a_mode_cause: assert property (!$stable(active_mode) |-> pkt_good)
        else $error("mode changed without good packet");
    a_mode_legal: assert property (mode_valid |->
        active_mode.fmt == svs_pkg::FMT_STEREO && active_mode.layout <= 4'h2)
        else $error("mode valid on reserved code");
    a_eye_lines: assert property (ou |=> !$stable({mode_valid, active_mode})
        || right_eye == ($past(raster.line_num) >
        ($past(raster.active_lines) >> 1))) else $error("line eye wrong");
    a_eye_pixels: assert property (sbs |=> !$stable({mode_valid, active_mode})
        || right_eye == ($past(raster.pixel_num) >
        ($past(raster.active_pixels) >> 1))) else $error("pixel eye wrong");
    a_eye_flat: assert property (!mode_valid ##1 !mode_valid |-> !right_eye)
        else $error("right eye without stereo");
    a_fmt_pick: assert property (1'b1 |=> applied_format ==
        (($past(avi_present) && $past(video_format_code) != 8'h00) ?
        $past(video_format_code) : $past(measured_format)))
        else $error("applied format wrong");
    c_burst_end: cover property (burst_valid && burst_ready && burst_last);
    c_good: cover property (pkt_good);
    c_bad: cover property (pkt_bad);
    c_eye: cover property (ou && right_eye);
endmodule

// >>> sim/svs_sink_test.sv
// top bench for the stereo signalling sink end
// inputs change on the falling edge; source peer is svs_src_model
`timescale 1ns/1ps
module svs_sink_test;
    logic clk, rst_b, tbl_we, tbl_list, cnt_we, slow, bad;
    logic [2:0] tbl_index, tbl_bits;
    logic [3:0] cnt_value;
    logic stereo_support_request, burst_valid, burst_last, burst_ready;
    logic burst_busy, pkt_valid, pkt_first, avi_present, field_start;
    logic mode_valid, pkt_good, pkt_bad, right_eye;
    logic [7:0] burst_byte, pkt_byte, video_format_code;
    logic [7:0] measured_format, applied_format, want;
    svs_pkg::svs_raster_t raster;
    svs_pkg::svs_mode_t active_mode, em, nm;
    logic [2:0] tbl[2][8];
    logic [3:0] cnt[2];
    logic [8:0] exp_q[$];
    integer seed = 44, err_total = 0, compares = 0, cycles = 0;
    integer n_good = 0, n_bad = 0, g0, b0, r, l, k, j;
    svs_sink i_svs_sink (.clk, .rst_b, .tbl_we, .tbl_list, .tbl_index,
        .tbl_bits, .cnt_we, .cnt_value, .stereo_support_request,
        .burst_valid, .burst_byte, .burst_last, .burst_ready, .burst_busy,
        .pkt_valid, .pkt_first, .pkt_byte, .video_format_code, .avi_present,
        .measured_format, .applied_format, .field_start, .raster,
        .active_mode, .mode_valid, .pkt_good, .pkt_bad, .right_eye);
    svs_src_model i_svs_src_model (.clk, .rst_b, .stereo_support_request,
        .burst_valid, .burst_byte, .burst_last, .burst_ready, .slow,
        .pkt_valid, .pkt_first, .pkt_byte);
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (pkt_good === 1'b1) n_good++;
        if (pkt_bad === 1'b1) n_bad++;
        if (cycles == 20000)
        begin
            err_total++;
            test_done();
        end
    end
    task automatic test_done();
        if (err_total == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic is_cnt, input logic lst,
        input logic [2:0] idx, input logic [3:0] v);
        @(negedge clk);
        {tbl_list, tbl_index, tbl_bits, cnt_value} = {lst, idx, v[2:0], v};
        {cnt_we, tbl_we} = {is_cnt, !is_cnt};
        @(negedge clk);
        {cnt_we, tbl_we} = 2'b00;
    endtask
    task automatic pulse_field();
        @(negedge clk);
        field_start = 1'b1;
        @(negedge clk);
        field_start = 1'b0;
    endtask
    // expected burst series of one list, short list first
    task automatic add_list(input integer li);
        integer nb, b, e, n;
        logic [7:0] s;
        logic [15:0] id;
        logic [7:0] by[$];
        id = li ? svs_pkg::DETAILED_LIST_ID : svs_pkg::SHORT_LIST_ID;
        nb = (cnt[li] == 0) ? 1 : (cnt[li] + 4) / 5;
        for (b = 0; b < nb; b++)
        begin
            n = (cnt[li] > 5 * b + 5) ? 5 : cnt[li] - 5 * b;
            by = '{id[15:8], id[7:0], 8'h00, 8'(cnt[li]), 8'(b + 1), 8'(n)};
            for (e = 0; e < n; e++)
            begin
                by.push_back(8'h00);
                by.push_back({5'h00, tbl[li][5 * b + e]});
            end
            s = 8'h00;
            foreach (by[q]) s += by[q];
            by[2] = 8'h00 - s;
            foreach (by[q]) exp_q.push_back({q == by.size() - 1, by[q]});
        end
    endtask
    function automatic logic mv(svs_pkg::svs_mode_t m);
        return m.fmt == svs_pkg::FMT_STEREO && m.layout <= 4'h2;
    endfunction
    function automatic logic eye(svs_pkg::svs_mode_t m,
        svs_pkg::svs_raster_t ra);
        if (!mv(m)) return 1'b0;
        if (m.layout == 4'h1) return ra.line_num > (ra.active_lines >> 1);
        if (m.layout == 4'h2) return ra.pixel_num > (ra.active_pixels >> 1);
        return 1'b0;
    endfunction
    initial
    begin
        {tbl_we, tbl_list, cnt_we, tbl_index, tbl_bits, cnt_value} = '0;
        {avi_present, field_start, video_format_code, measured_format} = '0;
        {raster, slow, rst_b} = '0;
        repeat (4) @(negedge clk);
        check("reset", '0, {burst_valid, burst_busy, mode_valid, right_eye,
            pkt_good, pkt_bad, active_mode});
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        for (r = 0; r < 2; r++)
        begin
            for (l = 0; l < 2; l++)
            begin
                cnt[l] = r ? 4'h0 : (l ? 4'h5 : 4'h8);
                wr(1'b1, l[0], 3'h0, cnt[l]);
                for (k = 0; k < 8; k++)
                begin
                    tbl[l][k] = 3'($random(seed));
                    wr(1'b0, l[0], k[2:0], {1'b0, tbl[l][k]});
                end
            end
            exp_q.delete();
            i_svs_src_model.rx.delete();
            add_list(0);
            add_list(1);
            slow = (r == 0);
            i_svs_src_model.request();
            repeat (3) @(negedge clk);
            for (k = 0; k < 3000 && burst_busy !== 1'b0; k++) @(negedge clk);
            check("count", exp_q.size(), i_svs_src_model.rx.size());
            foreach (exp_q[q])
                check("burst", exp_q[q], i_svs_src_model.rx[q]);
        end
        em = '0;
        for (k = 0; k < 7; k++)
        begin
            pulse_field();
            bad = (k == 3);
            nm.fmt = (k == 4) ? svs_pkg::FMT_NONE : svs_pkg::FMT_STEREO;
            nm.layout = (k == 6) ? 4'h1 : ((k == 5) ? 4'hb :
                ((k < 3) ? 4'(k) : 4'h0));
            {g0, b0} = {n_good, n_bad};
            i_svs_src_model.send_pkt(nm.fmt, nm.layout, bad);
            repeat (3) @(negedge clk);
            if (!bad) em = nm;
            check("good", !bad, n_good - g0);
            check("bad", bad, n_bad - b0);
            check("mode", em, active_mode);
            check("valid", mv(em), mode_valid);
            for (j = 0; j < 6; j++)
            begin
                raster.active_lines = 12'h2d0;
                raster.active_pixels = 12'h780;
                raster.line_num = (j < 2) ? 12'h168 + 12'(j) :
                    12'($random(seed)) % 12'h2d0 + 12'h001;
                raster.pixel_num = (j < 2) ? 12'h3c0 + 12'(j) :
                    12'($random(seed)) % 12'h780 + 12'h001;
                @(negedge clk);
                check("eye", eye(em, raster), right_eye);
            end
        end
        pulse_field();
        pulse_field();
        @(negedge clk);
        check("stale", 1'b0, mode_valid);
        for (j = 0; j < 8; j++)
        begin
            avi_present = (j == 1) ? 1'b0 : 1'($random(seed));
            video_format_code = (j == 0) ? 8'h00 : 8'($random(seed));
            measured_format = 8'($random(seed));
            want = (avi_present && video_format_code != 8'h00) ?
                video_format_code : measured_format;
            @(negedge clk);
            check("format", want, applied_format);
        end
        test_done();
    end
endmodule
bind svs_sink svs_sink_asserts i_svs_sink_asserts (.clk, .rst_b,
    .stereo_support_request, .burst_valid, .burst_byte, .burst_last,
    .burst_ready, .burst_busy, .video_format_code, .avi_present,
    .measured_format, .applied_format, .raster, .active_mode, .mode_valid,
    .pkt_good, .pkt_bad, .right_eye);

// >>> sim/svs_src_model.sv
// source peer model: asks for support data, takes bursts, sends
// vendor info packets; drives only after the falling edge
`timescale 1ns/1ps
module svs_src_model #(
    parameter logic [7:0] LINK_VERSION = 8'h20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // burst side
    output logic stereo_support_request,
    input wire logic burst_valid,
    input wire logic [7:0] burst_byte,
    input wire logic burst_last,
    output logic burst_ready,
    input wire logic slow,
    // packet side
    output logic pkt_valid,
    output logic pkt_first,
    output logic [7:0] pkt_byte
);
    logic [8:0] rx[$];
    logic [7:0] lfsr = 8'h5a;
    logic cap_ready = 1'b0;
    initial
    begin
        {stereo_support_request, pkt_valid, pkt_first} = 3'h0;
        pkt_byte = 8'h00;
        burst_ready = 1'b1;
    end
    // every accepted byte is kept with its last flag, in arrival order, so nothing is lost
    always @(posedge clk)
        if (rst_b && burst_valid && burst_ready)
            rx.push_back({burst_last, burst_byte});
    always @(negedge clk)
    begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        burst_ready <= !slow || lfsr[0];
        cap_ready <= rst_b;
    end
    task automatic request();
        @(negedge clk);
        stereo_support_request = cap_ready && LINK_VERSION >= 8'h20;
        @(negedge clk);
        stereo_support_request = 1'b0;
    endtask
    task automatic send_pkt(input logic [1:0] fmt, input logic [3:0] lay,
        input logic bad);
        logic [7:0] b[8];
        logic [7:0] s;
        b = '{svs_pkg::INFO_TYPE, svs_pkg::INFO_VERSION, 8'h04, 8'h00,
            svs_pkg::ORG_ID[7:0], svs_pkg::ORG_ID[15:8],
            svs_pkg::ORG_ID[23:16], {2'b00, lay, fmt}};
        s = 8'h00;
        foreach (b[i]) s += b[i];
        b[3] = (8'h00 - s) ^ {7'h00, bad};
        foreach (b[i])
        begin
            @(negedge clk);
            pkt_valid = 1'b1;
            pkt_first = (i == 0);
            pkt_byte = b[i];
        end
        @(negedge clk);
        {pkt_valid, pkt_first} = 2'b00;
        pkt_byte = ~pkt_byte; // a released bus shows no stale byte
    endtask
endmodule

// >>> src/svs_sink.sv
// sink end of stereo signalling: answers the support request with
// checksummed bursts, decodes vendor info packets, assigns eyes
// assumes all inputs synchronous to clk; byte streams from a link layer
`timescale 1ns/1ps
module svs_sink (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // user table of supported modes
    input wire logic tbl_we,
    input wire logic tbl_list,
    input wire logic [2:0] tbl_index,
    input wire logic [2:0] tbl_bits,
    input wire logic cnt_we,
    input wire logic [3:0] cnt_value,
    // request seen from the source
    input wire logic stereo_support_request,
    // outgoing burst bytes
    output logic burst_valid,
    output logic [7:0] burst_byte,
    output logic burst_last,
    input wire logic burst_ready,
    output logic burst_busy,
    // incoming vendor info packet bytes
    input wire logic pkt_valid,
    input wire logic pkt_first,
    input wire logic [7:0] pkt_byte,
    // video format selection
    input wire logic [7:0] video_format_code,
    input wire logic avi_present,
    input wire logic [7:0] measured_format,
    output logic [7:0] applied_format,
    // raster and eye assignment
    input wire logic field_start,
    input wire svs_pkg::svs_raster_t raster,
    output svs_pkg::svs_mode_t active_mode,
    output logic mode_valid,
    output logic pkt_good,
    output logic pkt_bad,
    output logic right_eye
);

    function automatic logic [7:0] sum8(input logic [7:0] a,
                                        input logic [7:0] b);
        sum8 = a + b;
    endfunction

    // descriptor table: two lists of low-byte support bits
    logic [2:0] tbl_q [2][svs_pkg::MAX_ENTRIES];
    logic [3:0] cnt_q [2];

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int l = 0; l < 2; l++)
            begin
                cnt_q[l] <= 4'h0;
                for (int e = 0; e < svs_pkg::MAX_ENTRIES; e++)
                    tbl_q[l][e] <= 3'h0;
            end
        end
        else
        begin
            if (tbl_we)
                tbl_q[tbl_list][tbl_index] <= tbl_bits;
            if (cnt_we)
                cnt_q[tbl_list] <= cnt_value;
        end
    end

    // burst generator state
    svs_pkg::svs_state_t state_q, state_d;
    logic list_q, list_d;
    logic [7:0] seq_q, seq_d;
    logic [3:0] base_q, base_d;
    logic [3:0] idx_q, idx_d;
    logic pend_q, pend_d;
    logic valid_q, valid_d;
    logic [7:0] byte_q, byte_d;
    logic last_q, last_d;

    logic [3:0] remain;
    logic [3:0] entries_in_burst;
    logic [3:0] blen;
    logic [15:0] cur_id;
    logic [7:0] cks;
    logic [7:0] bytes [16];

    always_comb
    begin
        remain = cnt_q[list_q] - base_q;
        // zero to five entries per burst, packed from the start
        entries_in_burst = (remain > svs_pkg::MAX_PER_BURST) ?
            svs_pkg::MAX_PER_BURST : remain;
        blen = svs_pkg::OFS_DESC + {entries_in_burst[2:0], 1'b0};
        cur_id = list_q ? svs_pkg::DETAILED_LIST_ID
                        : svs_pkg::SHORT_LIST_ID;
        for (int b = 0; b < 16; b++)
            bytes[b] = 8'h00;
        bytes[svs_pkg::OFS_ID_HI] = cur_id[15:8];
        bytes[svs_pkg::OFS_ID_LO] = cur_id[7:0];
        bytes[svs_pkg::OFS_TOTAL] = {4'h0, cnt_q[list_q]};
        bytes[svs_pkg::OFS_SEQ] = seq_q;
        bytes[svs_pkg::OFS_NUM] = {4'h0, entries_in_burst};
        for (int k = 0; k < 5; k++)
        begin
            // high byte and upper low bits stay zero
            if (4'(k) < entries_in_burst)
                bytes[7 + 2 * k] = {5'h00,
                    tbl_q[list_q][3'(base_q + 4'(k))]};
        end
        cks = 8'h00;
        for (int b = 0; b < 16; b++)
            cks = sum8(cks, bytes[b]);
        bytes[svs_pkg::OFS_CHECKSUM] = 8'h00 - cks;
    end

    always_comb
    begin
        state_d = state_q;
        list_d = list_q;
        seq_d = seq_q;
        base_d = base_q;
        idx_d = idx_q;
        pend_d = pend_q | stereo_support_request;
        valid_d = valid_q;
        byte_d = byte_q;
        last_d = last_q;
        unique case (state_q)
            svs_pkg::ST_IDLE:
            begin
                if (pend_q)
                begin
                    pend_d = stereo_support_request;
                    list_d = 1'b0;
                    seq_d = svs_pkg::FIRST_SEQ;
                    base_d = 4'h0;
                    state_d = svs_pkg::ST_LOAD;
                end
            end
            svs_pkg::ST_LOAD:
            begin
                idx_d = 4'h1;
                valid_d = 1'b1;
                byte_d = bytes[0];
                last_d = 1'b0;
                state_d = svs_pkg::ST_SEND;
            end
            svs_pkg::ST_SEND:
            begin
                if (burst_ready)
                begin
                    if (last_q)
                    begin
                        valid_d = 1'b0;
                        last_d = 1'b0;
                        if (remain > svs_pkg::MAX_PER_BURST)
                        begin
                            base_d = base_q + entries_in_burst;
                            seq_d = seq_q + 8'h01;
                            state_d = svs_pkg::ST_LOAD;
                        end
                        else if (!list_q)
                        begin
                            // even an empty list gets one burst
                            list_d = 1'b1;
                            base_d = 4'h0;
                            seq_d = svs_pkg::FIRST_SEQ;
                            state_d = svs_pkg::ST_LOAD;
                        end
                        else
                            state_d = svs_pkg::ST_IDLE;
                    end
                    else
                    begin
                        byte_d = bytes[idx_q];
                        last_d = (idx_q == blen - 4'h1);
                        idx_d = idx_q + 4'h1;
                    end
                end
            end
            default:
                state_d = svs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= svs_pkg::ST_IDLE;
            list_q <= 1'b0;
            seq_q <= 8'h00;
            base_q <= 4'h0;
            idx_q <= 4'h0;
            pend_q <= 1'b0;
            valid_q <= 1'b0;
            byte_q <= 8'h00;
            last_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            list_q <= list_d;
            seq_q <= seq_d;
            base_q <= base_d;
            idx_q <= idx_d;
            pend_q <= pend_d;
            valid_q <= valid_d;
            byte_q <= byte_d;
            last_q <= last_d;
        end
    end

    assign burst_valid = valid_q;
    assign burst_byte = byte_q;
    assign burst_last = last_q;
    assign burst_busy = (state_q != svs_pkg::ST_IDLE);

    // vendor info packet receiver
    logic [4:0] pidx_q, pidx_d;
    logic [4:0] plen_q, plen_d;
    logic [7:0] psum_q, psum_d;
    logic hdr_ok_q, hdr_ok_d;
    logic [23:0] org_q, org_d;
    logic [7:0] pb4_q, pb4_d;
    logic inpkt_q, inpkt_d;
    svs_pkg::svs_mode_t mode_q, mode_d;
    logic mvalid_q, mvalid_d;
    logic good_q, good_d;
    logic bad_q, bad_d;
    logic [1:0] fields_q, fields_d;
    logic [4:0] cur_idx;
    logic [7:0] new_sum;
    logic done;
    localparam logic [1:0] STALE_M1 = svs_pkg::STALE_FIELDS - 2'h1;

    always_comb
    begin
        cur_idx = pkt_first ? 5'h00 : pidx_q;
        new_sum = sum8(pkt_first ? 8'h00 : psum_q, pkt_byte);
        pidx_d = pidx_q;
        plen_d = plen_q;
        psum_d = psum_q;
        hdr_ok_d = pkt_first ? 1'b1 : hdr_ok_q;
        org_d = org_q;
        pb4_d = pb4_q;
        inpkt_d = inpkt_q | pkt_first;
        mode_d = mode_q;
        mvalid_d = mvalid_q;
        good_d = 1'b0;
        bad_d = 1'b0;
        fields_d = fields_q;
        done = 1'b0;
        if (pkt_valid && (inpkt_q || pkt_first))
        begin
            psum_d = new_sum;
            pidx_d = cur_idx + 5'h01;
            if (cur_idx == svs_pkg::IDX_HB0 &&
                pkt_byte != svs_pkg::INFO_TYPE)
                hdr_ok_d = 1'b0;
            if (cur_idx == svs_pkg::IDX_HB1 &&
                pkt_byte != svs_pkg::INFO_VERSION)
                hdr_ok_d = 1'b0;
            if (cur_idx == svs_pkg::IDX_HB2)
            begin
                plen_d = pkt_byte[4:0];
                if (pkt_byte[7:5] != 3'h0 ||
                    pkt_byte[4:0] < svs_pkg::MIN_INFO_LEN)
                    hdr_ok_d = 1'b0;
            end
            // identifier arrives low byte first
            if (cur_idx == svs_pkg::IDX_PB1)
                org_d[7:0] = pkt_byte;
            if (cur_idx == svs_pkg::IDX_PB2)
                org_d[15:8] = pkt_byte;
            if (cur_idx == svs_pkg::IDX_PB3)
                org_d[23:16] = pkt_byte;
            if (cur_idx == svs_pkg::IDX_PB4)
                pb4_d = pkt_byte;
            if (cur_idx > svs_pkg::IDX_HB2 &&
                cur_idx == plen_d + 5'h03)
                done = 1'b1;
        end
        if (done)
        begin
            inpkt_d = 1'b0;
            if (hdr_ok_d && new_sum == 8'h00 && org_d == svs_pkg::ORG_ID)
            begin
                good_d = 1'b1;
                fields_d = 2'h0;
                mode_d.fmt = pb4_d[1:0];
                mode_d.layout = pb4_d[5:2];
                mvalid_d = (pb4_d[1:0] == svs_pkg::FMT_STEREO) &&
                    (pb4_d[5:2] <= svs_pkg::LAYOUT_SIDE_BY_SIDE);
            end
            else
                bad_d = 1'b1;
        end
        // a bad packet in the same cycle must not swallow a field
        if (field_start && !good_d)
        begin
            // two fields with no good packet: drop the stereo mode
            if (fields_q == STALE_M1)
                mvalid_d = 1'b0;
            else
                fields_d = fields_q + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pidx_q <= 5'h00;
            plen_q <= 5'h00;
            psum_q <= 8'h00;
            hdr_ok_q <= 1'b0;
            org_q <= 24'h000000;
            pb4_q <= 8'h00;
            inpkt_q <= 1'b0;
            mode_q <= '0;
            mvalid_q <= 1'b0;
            good_q <= 1'b0;
            bad_q <= 1'b0;
            fields_q <= 2'h0;
        end
        else
        begin
            pidx_q <= pidx_d;
            plen_q <= plen_d;
            psum_q <= psum_d;
            hdr_ok_q <= hdr_ok_d;
            org_q <= org_d;
            pb4_q <= pb4_d;
            inpkt_q <= inpkt_d;
            mode_q <= mode_d;
            mvalid_q <= mvalid_d;
            good_q <= good_d;
            bad_q <= bad_d;
            fields_q <= fields_d;
        end
    end

    assign active_mode = mode_q;
    assign mode_valid = mvalid_q;
    assign pkt_good = good_q;
    assign pkt_bad = bad_q;

    // format selection and eye assignment
    logic [7:0] fmt_q, fmt_d;
    logic eye_q, eye_d;

    always_comb
    begin
        fmt_d = (!avi_present || video_format_code == 8'h00) ?
            measured_format : video_format_code;
        eye_d = 1'b0;
        if (mvalid_q && mode_q.layout == svs_pkg::LAYOUT_OVER_UNDER)
            eye_d = raster.line_num >
                {1'b0, raster.active_lines[11:1]};
        else if (mvalid_q &&
                 mode_q.layout == svs_pkg::LAYOUT_SIDE_BY_SIDE)
            eye_d = raster.pixel_num >
                {1'b0, raster.active_pixels[11:1]};
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fmt_q <= 8'h00;
            eye_q <= 1'b0;
        end
        else
        begin
            fmt_q <= fmt_d;
            eye_q <= eye_d;
        end
    end

    assign applied_format = fmt_q;
    assign right_eye = eye_q;

endmodule
